/* File: bench/aic_core_checker.sv */
// Port-level assertions for the interrupt and limit status block
`default_nettype none
module aic_core_checker
	import aic_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = 20
) (
	input wire logic              clk_i,              // clock
	input wire logic              reset_i,            // sync reset
	input wire logic              ce_i,               // clock enable
	input wire logic              bus_width_select_i, // byte bus
	input wire logic [ADDR_W-1:0] byte_addr_lines_i,  // address
	input wire logic              rd_i,               // read strobe
	input wire logic              wr_i,               // write strobe
	input wire logic [DATA_W-1:0] wdata_i,            // write data
	input wire logic [DATA_W-1:0] rdata_o,            // read data
	input wire logic              low_supply_pin_i,   // supply detector
	input wire aic_events_t       ev_i,               // sequencer events
	input wire logic              irq_n_o             // interrupt pin
);
	localparam int LO = SETTLE_CYCLES;
	localparam int HI = SETTLE_CYCLES + 6;
	logic      [DATA_W-1:0] msk_q;
	wire logic              rd_w = ce_i && rd_i && !bus_width_select_i;
	wire logic [3:0]        a_w  = byte_addr_lines_i[3:0];
	// Shadow of the mask; word mode only
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			msk_q <= '0;
		end else if (ce_i && wr_i && !bus_width_select_i && a_w == ADDR_IRQ_MASK) begin
			msk_q <= wdata_i;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	rst_quiet_a: assert property (disable iff (1'b0) reset_i |=> irq_n_o && rdata_o == '0)
		else $error("pin or data not idle after reset");
	mask_zero_a: assert property (msk_q[7:0] == 8'h00 && !wr_i |=> irq_n_o)
		else $error("masked flag drove the pin");
	cal_irq_a: assert property (ce_i && ev_i.full_cal_done && msk_q[SRC_FULL_CAL] && !wr_i ##1 ce_i && !rd_w
		|=> !irq_n_o)
		else $error("calibration flag did not drive the pin");
	match_irq_a: assert property (ce_i && ev_i.fetch && ev_i.ip == msk_q[10:8] && msk_q[10:8] != 3'h0
		&& msk_q[SRC_MATCH] && !wr_i ##1 ce_i && !rd_w |=> !irq_n_o)
		else $error("address match did not drive the pin");
	low_sup_a: assert property ($rose(low_supply_pin_i) && msk_q[SRC_LOW_SUP] |-> ##[2:6] !irq_n_o)
		else $error("low supply did not drive the pin");
	stby_exit_a: assert property ($fell(ev_i.standby) && msk_q[SRC_STBY_EXIT] |-> ##[LO:HI] !irq_n_o)
		else $error("standby exit not signalled in time");
	mask_rd_a: assert property (rd_w && a_w == ADDR_IRQ_MASK && !wr_i |=> rdata_o == msk_q)
		else $error("mask readback wrong");
	unmapped_a: assert property (rd_w && a_w < 4'h9 |=> rdata_o == '0)
		else $error("unmapped read not zero");
	progress_a: assert property (rd_w && a_w == ADDR_IRQ_FLAG |=> rdata_o[15:8] ==
		($past(ev_i.running) ? {$past(ev_i.fifo_count), $past(ev_i.ip)} : 8'h00))
		else $error("status progress field wrong");
endmodule
bind aic_core aic_core_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk (.clk_i(clk_i), .reset_i(reset_i),
	.ce_i(ce_i), .bus_width_select_i(bus_width_select_i), .byte_addr_lines_i(byte_addr_lines_i),
	.rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .low_supply_pin_i(low_supply_pin_i),
	.ev_i(ev_i), .irq_n_o(irq_n_o));
`default_nettype wire

/* File: bench/aic_host_model.sv */
// Host processor model on the register bus
`default_nettype none
module aic_host_model
	import aic_pkg::*;
(
	input  wire logic              clk_i,   // bus clock
	output logic                   rd_o,    // read strobe
	output logic                   wr_o,    // write strobe
	output logic      [ADDR_W-1:0] addr_o,  // address lines
	output logic      [DATA_W-1:0] wdata_o  // write data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = '0;
		wdata_o = '0;
	end
	// Released address and data lines are inverted so stale values never look valid; strobes return to 0
	task automatic access(input logic w, input logic [3:0] a, input logic [DATA_W-1:0] d);
		@(negedge clk_i);
		rd_o = !w;
		wr_o = w;
		addr_o = {1'b0, a};
		wdata_o = d;
		@(negedge clk_i);
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = ~addr_o;
		wdata_o = ~wdata_o;
	endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the interrupt and limit status block
`default_nettype none
module tb_top
	import aic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SETTLE = 20;
	// Pause qualifier lives only with its fetch; left standing it would flag every later fetch
	localparam aic_events_t PULSES = '{full_cal_done: 1'b1, short_az_done: 1'b1, fetch: 1'b1, fetch_pause: 1'b1,
		seq_start: 1'b1, lim1_hit: 1'b1, lim2_hit: 1'b1, default: '0};
	logic              clk = 1'b0;
	logic              reset = 1'b1;
	logic              pin = 1'b0;
	logic              ce = 1'b1;
	logic              rd, wr, irq_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wd, rdata;
	aic_events_t       ev = '0;
	int                miscompares = 0;
	int                checks = 0;
	always #50 clk = ~clk;
	aic_host_model host (.clk_i(clk), .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wd));
	aic_core #(.SETTLE_CYCLES(SETTLE)) DUT (.clk_i(clk), .reset_i(reset), .ce_i(ce),
		.bus_width_select_i(1'b0), .byte_addr_lines_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wd),
		.rdata_o(rdata), .low_supply_pin_i(pin), .ev_i(ev), .irq_n_o(irq_n));
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h", $time, what, got);
		end
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [DATA_W-1:0] exp, input string what);
		host.access(1'b0, a, 16'h0000);
		chk(rdata, exp, what);
	endtask
	task automatic fire(input aic_events_t e);
		@(negedge clk);
		ev = aic_events_t'(ev | e);
		@(negedge clk);
		ev = aic_events_t'(ev & ~PULSES);
	endtask
	task automatic setmask(input logic [DATA_W-1:0] m);
		host.access(1'b1, ADDR_IRQ_MASK, m);
		host.access(1'b0, ADDR_IRQ_FLAG, 16'h0000);
	endtask
	task automatic results();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic t_regs();
		rdchk(ADDR_IRQ_MASK, 16'h0000, "mask reset");
		rdchk(ADDR_LIMIT, 16'h0000, "limit reset");
		host.access(1'b1, 4'h3, 16'hFFFF);
		rdchk(4'h3, 16'h0000, "unmapped");
		setmask(16'hA5C3);
		rdchk(ADDR_IRQ_MASK, 16'hA5C3, "mask readback");
		host.access(1'b1, ADDR_IRQ_FLAG, 16'hFFFF);
		rdchk(ADDR_IRQ_FLAG, 16'h0000, "status write");
		$display("test registers done");
	endtask
	task automatic t_flags();
		setmask(16'h0000);
		fire('{seq_start: 1'b1, default: '0});
		fire('{fetch: 1'b1, fetch_pause: 1'b1, default: '0});
		rdchk(ADDR_IRQ_FLAG, 16'h0020, "pause, first zero fetch");
		fire('{fetch: 1'b1, default: '0});
		rdchk(ADDR_IRQ_FLAG, 16'h0002, "second zero fetch");
		fire('{full_cal_done: 1'b1, short_az_done: 1'b1, default: '0});
		chk(16'(irq_n), 16'h0001, "masked pin");
		rdchk(ADDR_IRQ_FLAG, 16'h0018, "calibration flags");
		rdchk(ADDR_IRQ_FLAG, 16'h0000, "read clear");
		setmask(16'h0010);
		fire('{full_cal_done: 1'b1, default: '0});
		repeat (2) @(negedge clk);
		chk(16'(irq_n), 16'h0000, "pin asserted");
		rdchk(ADDR_IRQ_FLAG, 16'h0010, "enabled flag");
		@(negedge clk);
		chk(16'(irq_n), 16'h0001, "pin released");
		// Clock enable low: an event must leave no trace
		ce = 1'b0;
		fire('{full_cal_done: 1'b1, default: '0});
		ce = 1'b1;
		chk(16'(irq_n), 16'h0001, "frozen pin");
		rdchk(ADDR_IRQ_FLAG, 16'h0000, "frozen flags");
		$display("test flags done");
	endtask
	task automatic t_limit();
		@(negedge clk);
		ev.ip = 3'h3;
		fire('{lim1_hit: 1'b1, default: '0});
		ev.ip = 3'h6;
		fire('{lim2_hit: 1'b1, default: '0});
		rdchk(ADDR_LIMIT, 16'h4008, "limit bits");
		rdchk(ADDR_IRQ_FLAG, 16'h0001, "watchdog flag");
		rdchk(ADDR_LIMIT, 16'h0000, "limit clear");
		setmask(16'h4D06);
		ev.running = 1'b1;
		ev.ip = 3'h5;
		ev.fifo_count = 5'h08;
		rdchk(ADDR_IRQ_FLAG, 16'h4500, "progress");
		ev.fifo_count = 5'h09;
		fire('{fetch: 1'b1, default: '0});
		rdchk(ADDR_IRQ_FLAG, 16'h4D06, "match and count");
		ev = '0;
		$display("test limit and progress done");
	endtask
	task automatic t_supply();
		int n;
		setmask(16'h0040);
		pin = 1'b1;
		repeat (8) @(negedge clk);
		rdchk(ADDR_IRQ_FLAG, 16'h0040, "low supply");
		setmask(16'h0080);
		ev.standby = 1'b1;
		@(negedge clk);
		ev.standby = 1'b0;
		for (n = 0; n < 200 && irq_n !== 1'b0; n++) @(negedge clk);
		if (n == 200) begin
			miscompares++;
			results();
		end
		chk(16'(n >= SETTLE && n <= SETTLE + 6), 16'h0001, "settle delay");
		rdchk(ADDR_IRQ_FLAG, 16'h0080, "standby exit");
		$display("test supply and standby done");
	endtask
	initial begin
		repeat (16) @(negedge clk);
		reset = 1'b0;
		t_regs();
		t_flags();
		t_limit();
		t_supply();
		results();
	end
endmodule
`default_nettype wire

/* File: verilog/aic_core.sv */
// Interrupt collection, mask and limit status registers
// Functional notes
// - Full calibration done raises source 4
// - Fetched pause instruction raises source 5
// - Low supply detection raises source 6
// - Standby exit waits 10 ms, raises 7
// - Enabled sources only drive interrupt pin
// - Flags set regardless of enable bits
// - Enable bits 0-7 mask sources in order
// - Enable bits 8-10 hold match address
// - Match zero skips first fetch after start
// - Interrupts never stop the sequencer
// - Enable bits 11-15 hold FIFO threshold
// - Status read clears flags; reset too
// - Status bits 0-7 report sources in order
// - Status bits 8-10 show instruction pointer while running
// - Status bits 11-15 show FIFO count while running
// - Limit crossing sets bit by instruction
// - Limit bits 0-7 record first limit
// - Limit register read clears; reset too
// - Registers at word addresses 9, A, D
// - Limit bits 8-15 record second limit
// - Match raised before instruction executes
// - Watchdog crossing raises source 0
`default_nettype none
module aic_core
	import aic_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = (SETTLE_MS * (CLK_HZ / 1000))
) (
	input  wire logic              clk_i,              // 10 MHz clock
	input  wire logic              reset_i,            // sync reset, high
	input  wire logic              ce_i,               // clock enable
	input  wire logic              bus_width_select_i, // 1 = byte bus
	input  wire logic [ADDR_W-1:0] byte_addr_lines_i,  // address, bit 0 byte select in byte mode
	input  wire logic              rd_i,               // read strobe, one cycle
	input  wire logic              wr_i,               // write strobe, one cycle
	input  wire logic [DATA_W-1:0] wdata_i,            // write data
	output logic      [DATA_W-1:0] rdata_o,            // read data, registered
	input  wire logic              low_supply_pin_i,   // supply detector, asynchronous
	input  wire aic_events_t       ev_i,               // sequencer side events
	output logic                   irq_n_o             // interrupt pin, active low
);
	logic [DATA_W-1:0]  mask_q;
	logic [NUM_SRC-1:0] flag_q;
	logic [NUM_SRC-1:0] flag_d;
	logic [DATA_W-1:0]  lim_q;
	logic [DATA_W-1:0]  lim_d;
	logic               sup_meta_q;
	logic               sup_sync_q;
	logic               sup_prev_q;
	logic               first_zero_q;
	logic [CNT_W-1:0]   cnt_prev_q;
	logic               stby_done;

	// Word address from upper lines in byte mode, lower lines otherwise
	wire [3:0] word_addr_lines = bus_width_select_i ? byte_addr_lines_i[4:1]
	                                                 : byte_addr_lines_i[3:0];
	wire       byte_hi    = bus_width_select_i & byte_addr_lines_i[0];
	wire       sel_mask   = (word_addr_lines == ADDR_IRQ_MASK);
	wire       sel_flag   = (word_addr_lines == ADDR_IRQ_FLAG);
	wire       sel_lim    = (word_addr_lines == ADDR_LIMIT);
	// In byte mode each byte read clears only after the high byte is fetched
	wire       rd_last    = rd_i & (~bus_width_select_i | byte_hi);
	wire       clr_flag   = rd_last & sel_flag;
	wire       clr_lim    = rd_last & sel_lim;

	wire [IP_W-1:0]  match_addr = mask_q[MATCH_LSB +: IP_W];
	wire [CNT_W-1:0] threshold  = mask_q[THRESH_LSB +: CNT_W];

	// Match on fetch, ahead of execution; zero skipped on first fetch
	wire match_hit = ev_i.fetch & (ev_i.ip == match_addr)
	                 & ~((match_addr == '0) & first_zero_q);
	// FIFO threshold reached when the count steps onto it; zero means nothing
	wire fifo_hit  = (threshold != '0) & (ev_i.fifo_count == threshold)
	                 & (cnt_prev_q != threshold);
	wire sup_rise  = sup_sync_q & ~sup_prev_q;

	wire [NUM_SRC-1:0] events = {
		stby_done,
		sup_rise,
		ev_i.fetch & ev_i.fetch_pause,
		ev_i.full_cal_done,
		ev_i.short_az_done,
		fifo_hit,
		match_hit,
		ev_i.lim1_hit | ev_i.lim2_hit
	};

	// Set beats clear in the same cycle; mask plays no part here
	assign flag_d = (clr_flag ? '0 : flag_q) | events;

	// Limit bit chosen by the executing instruction's number
	logic [DATA_W-1:0] lim_set;
	always_comb begin
		lim_set = '0;
		lim_set[ev_i.ip] = ev_i.lim1_hit;
		lim_set[NUM_SRC + ev_i.ip] = ev_i.lim2_hit;
	end
	assign lim_d = (clr_lim ? '0 : lim_q) | lim_set;

	wire [DATA_W-1:0] flag_word = {
		ev_i.running ? ev_i.fifo_count : {CNT_W{1'b0}},
		ev_i.running ? ev_i.ip : {IP_W{1'b0}},
		flag_q
	};
	wire [DATA_W-1:0] rd_word = sel_mask ? mask_q :
	                            sel_flag ? flag_word :
	                            sel_lim  ? lim_q : '0;
	wire [7:0] rd_byte = byte_hi ? rd_word[15:8] : rd_word[7:0];

	// Pin reflects enabled flags only; the sequencer never sees it
	wire irq_any = |(flag_q & mask_q[NUM_SRC-1:0]);

	aic_settle_timer #(
		.COUNT (SETTLE_CYCLES)
	) u_settle (
		.clk_i     (clk_i),
		.reset_i   (reset_i),
		.ce_i      (ce_i),
		.standby_i (ev_i.standby),
		.done_o    (stby_done)
	);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sup_meta_q <= 1'b0;
			sup_sync_q <= 1'b0;
			sup_prev_q <= 1'b0;
		end else if (ce_i) begin
			sup_meta_q <= low_supply_pin_i;
			sup_sync_q <= sup_meta_q;
			sup_prev_q <= sup_sync_q;
		end
	end

	// Armed at each start; cleared once instruction zero has been fetched
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			first_zero_q <= 1'b1;
		end else if (ce_i) begin
			if (ev_i.seq_start) begin
				first_zero_q <= 1'b1;
			end else if (ev_i.fetch & (ev_i.ip == '0)) begin
				first_zero_q <= 1'b0;
			end
		end
	end

	// Byte writes update one half; word writes the whole register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mask_q <= MASK_RESET;
		end else if (ce_i & wr_i & sel_mask) begin
			if (!bus_width_select_i) begin
				mask_q <= wdata_i;
			end else if (byte_hi) begin
				mask_q[15:8] <= wdata_i[7:0];
			end else begin
				mask_q[7:0] <= wdata_i[7:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			flag_q     <= '0;
			lim_q      <= '0;
			cnt_prev_q <= '0;
			rdata_o    <= '0;
			irq_n_o    <= 1'b1;
		end else if (ce_i) begin
			flag_q     <= flag_d;
			lim_q      <= lim_d;
			cnt_prev_q <= ev_i.fifo_count;
			irq_n_o    <= ~irq_any;
			if (rd_i) begin
				rdata_o <= bus_width_select_i ? {8'h00, rd_byte} : rd_word;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verilog/aic_pkg.sv */
// Package for the converter interrupt and limit status block
`default_nettype none
package aic_pkg;
	localparam int unsigned DATA_W        = 16;
	localparam int unsigned ADDR_W        = 5;
	localparam int unsigned NUM_SRC       = 8;
	localparam int unsigned IP_W          = 3;
	localparam int unsigned CNT_W         = 5;
	// Word addresses on word_addr_lines
	localparam logic [3:0]  ADDR_IRQ_MASK = 4'h9;
	localparam logic [3:0]  ADDR_IRQ_FLAG = 4'hA;
	localparam logic [3:0]  ADDR_LIMIT    = 4'hD;
	// Source numbers
	localparam int unsigned SRC_WDOG      = 0;
	localparam int unsigned SRC_MATCH     = 1;
	localparam int unsigned SRC_FIFO      = 2;
	localparam int unsigned SRC_SHORT_AZ  = 3;
	localparam int unsigned SRC_FULL_CAL  = 4;
	localparam int unsigned SRC_PAUSE     = 5;
	localparam int unsigned SRC_LOW_SUP   = 6;
	localparam int unsigned SRC_STBY_EXIT = 7;
	// Field positions within the mask register
	localparam int unsigned MATCH_LSB     = 8;
	localparam int unsigned THRESH_LSB    = 11;
	localparam logic [DATA_W-1:0] MASK_RESET = 16'h0000;
	// Standby exit settling time
	localparam int unsigned SETTLE_MS     = 10;
	localparam int unsigned CLK_HZ        = 10000000;

	typedef struct packed {
		logic            full_cal_done;  // full calibration finished
		logic            short_az_done;  // short auto-zero finished
		logic            low_supply;     // low-supply detector level
		logic            standby;        // standby bit
		logic            fetch;          // instruction fetch strobe
		logic            fetch_pause;    // fetched instruction has pause set
		logic [IP_W-1:0] ip;             // instruction pointer
		logic            running;        // sequencer running
		logic            seq_start;      // sequencer start from halted
		logic [CNT_W-1:0] fifo_count;    // results in FIFO
		logic            lim1_hit;       // limit 1 crossing strobe
		logic            lim2_hit;       // limit 2 crossing strobe
	} aic_events_t;
endpackage
`default_nettype wire

/* File: verilog/aic_settle_timer.sv */
// Standby exit settling delay counter
`default_nettype none
module aic_settle_timer #(
	parameter int unsigned COUNT = 100000
) (
	input  wire logic clk_i,    // clock
	input  wire logic reset_i,  // sync reset
	input  wire logic ce_i,     // clock enable
	input  wire logic standby_i,// standby bit
	output logic      done_o    // one-cycle pulse after delay
);
	localparam int unsigned CW = $clog2(COUNT + 1);
	logic [CW-1:0] cnt_q;
	logic          busy_q;
	logic          stby_q;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
			stby_q <= 1'b0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			stby_q <= standby_i;
			done_o <= 1'b0;
			if (standby_i) begin
				busy_q <= 1'b0;
			end else if (stby_q) begin
				busy_q <= 1'b1;
				cnt_q  <= CW'(COUNT - 1);
			end else if (busy_q) begin
				if (cnt_q == '0) begin
					busy_q <= 1'b0;
					done_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire
